// ==== ats_pkg.sv ====
// Package of constants and types for the analyzer trigger sequencer
package ats_pkg;
  localparam int POD_BITS = 17;
  localparam int PAT_PER_POD = 4;
  localparam int RANGE_PER_POD = 1;
  localparam int MAX_LEVELS = 4;
  localparam int LEVEL_W = 2;
  localparam int HALF_CH_BITS = 8;
  localparam int HALF_CH_MAX_LEVELS = 2;
  localparam int HALF_CH_PATS = 3;
  localparam logic [LEVEL_W-1:0] LEVEL_RESET = 2'h0;
  localparam int SYNC_STAGES = 3;
  typedef enum logic [1:0] {
    ATS_MODE_IMMEDIATE,
    ATS_MODE_EVENTUAL,
    ATS_MODE_HALF_IMM,
    ATS_MODE_HALF_EVT
  } ats_mode_t;
  typedef enum {
    ATS_IDLE,
    ATS_ARMED,
    ATS_POST,
    ATS_DONE,
    ATS_REJECT
  } ats_state_t;
endpackage : ats_pkg

// ==== ats_pod_if.sv ====
// Interface carrying one pod's comparator setup and match results
`timescale 1ns/1ps
`default_nettype none
interface ats_pod_if #(
  parameter int WIDTH = 17,
  parameter int NPAT = 4
);
  logic [WIDTH-1:0] sample;
  logic [NPAT-1:0][WIDTH-1:0] value;
  logic [NPAT-1:0][WIDTH-1:0] mask;
  logic [WIDTH-1:0] range_lo;
  logic [WIDTH-1:0] range_hi;
  logic [NPAT-1:0] pat_hit;
  logic in_range;
  modport cfg (output sample, value, mask, range_lo, range_hi,
    input pat_hit, in_range);
  modport cmp (input sample, value, mask, range_lo, range_hi,
    output pat_hit, in_range);
endinterface : ats_pod_if
`default_nettype wire

// ==== ats_pod_cmp.sv ====
// One pod's pattern and range comparators
`timescale 1ns/1ps
`default_nettype none
module ats_pod_cmp #(
  parameter int WIDTH = 17,
  parameter int NPAT = 4
) (
  input wire logic clock,
  input wire logic resetn,
  ats_pod_if.cmp pod
);
  import ats_pkg::*;
  // Registered so every level sees results of the same sample
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pod.pat_hit <= '0;
    end else begin
      for (int i = 0; i < NPAT; i++) begin
        // Bits whose mask bit is clear are don't-care digits
        pod.pat_hit[i] <= ((pod.sample ^ pod.value[i]) & pod.mask[i])
          == '0;
      end
    end
  end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pod.in_range <= 1'b0;
    end else begin
      pod.in_range <= (pod.sample >= pod.range_lo) &&
        (pod.sample <= pod.range_hi);
    end
  end
endmodule : ats_pod_cmp
`default_nettype wire

// ==== ats_sequencer.sv ====
// Trigger sequencer and store qualifier for a set of probe pods
`timescale 1ns/1ps
`default_nettype none
module ats_sequencer #(
  parameter int NPODS = 2,
  parameter int DEPTH = 1024,
  parameter int COMBINERS = 8
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [NPODS*ats_pkg::POD_BITS-1:0] probe,
  input wire logic flag_in,
  input wire logic start,
  input wire ats_pkg::ats_mode_t mode,
  input wire logic [ats_pkg::LEVEL_W-1:0] last_level,
  input wire logic [NPODS*ats_pkg::PAT_PER_POD*ats_pkg::POD_BITS-1:0]
    pat_value,
  input wire logic [NPODS*ats_pkg::PAT_PER_POD*ats_pkg::POD_BITS-1:0]
    pat_mask,
  input wire logic [NPODS*ats_pkg::POD_BITS-1:0] range_lo,
  input wire logic [NPODS*ats_pkg::POD_BITS-1:0] range_hi,
  input wire logic [ats_pkg::MAX_LEVELS*NPODS*ats_pkg::PAT_PER_POD-1:0]
    level_and_use,
  input wire logic [ats_pkg::MAX_LEVELS*NPODS*ats_pkg::PAT_PER_POD-1:0]
    level_or_use,
  input wire logic [ats_pkg::MAX_LEVELS*NPODS-1:0] level_range_use,
  input wire logic [ats_pkg::MAX_LEVELS-1:0] level_flag_use,
  input wire logic store_qual_en,
  input wire logic [NPODS*ats_pkg::PAT_PER_POD-1:0] store_use,
  output logic [NPODS*ats_pkg::POD_BITS-1:0] store_data,
  output logic store_valid,
  output logic triggered,
  output logic done,
  output logic running,
  output logic reject,
  output logic [ats_pkg::LEVEL_W-1:0] level
);
  import ats_pkg::*;
  localparam int NP = NPODS * PAT_PER_POD;
  localparam int AW = $clog2(DEPTH);

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  // Probe words arrive on the sample clock: every word counts, none waits
  // The flag comes from another module and counts once two flops agree
  logic [NPODS*POD_BITS-1:0] probe_s1, probe_s2, probe_s3, probe_q;
  logic flag_s1, flag_s2, flag_s3, flag_q;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      probe_s1 <= '0;
      probe_s2 <= '0;
      probe_s3 <= '0;
      probe_q <= '0;
    end else begin
      probe_s1 <= probe;
      probe_s2 <= probe_s1;
      probe_s3 <= probe_s2;
      probe_q <= probe_s3;
    end
  end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      flag_s1 <= 1'b0;
      flag_s2 <= 1'b0;
      flag_s3 <= 1'b0;
      flag_q <= 1'b0;
    end else begin
      flag_s1 <= flag_in;
      flag_s2 <= flag_s1;
      flag_s3 <= flag_s2;
      if (flag_s2 == flag_s3) begin
        flag_q <= flag_s3;
      end
    end
  end

  // ------------------------------------------------------------
  // Pod comparators
  // ------------------------------------------------------------
  logic [NP-1:0] hit;
  logic [NPODS-1:0] rng_hit;
  logic [NPODS*POD_BITS-1:0] data_d1;
  logic flag_d1;
  logic [POD_BITS-1:0] half_mask;
  // Half channel masks pattern compares to the even data bits 0 to 14 of a pod; ranges and stored data keep all bits
  always_comb begin
    half_mask = '0;
    for (int b = 0; b < 2 * HALF_CH_BITS; b += 2) begin
      half_mask[b] = 1'b1;
    end
  end
  wire logic half = (mode == ATS_MODE_HALF_IMM) ||
    (mode == ATS_MODE_HALF_EVT);
  for (genvar p = 0; p < NPODS; p++) begin : g_pod
    ats_pod_if #(.WIDTH(POD_BITS), .NPAT(PAT_PER_POD)) pif ();
    always_comb begin
      pif.sample = probe_q[p*POD_BITS +: POD_BITS];
      pif.range_lo = range_lo[p*POD_BITS +: POD_BITS];
      pif.range_hi = range_hi[p*POD_BITS +: POD_BITS];
      for (int i = 0; i < PAT_PER_POD; i++) begin
        pif.value[i] = pat_value[(p*PAT_PER_POD+i)*POD_BITS +: POD_BITS];
        pif.mask[i] = pat_mask[(p*PAT_PER_POD+i)*POD_BITS +: POD_BITS]
          & (half ? half_mask : '1);
      end
    end
    ats_pod_cmp #(.WIDTH(POD_BITS), .NPAT(PAT_PER_POD)) u_cmp (
      .clock(clock),
      .resetn(resetn),
      .pod(pif.cmp)
    );
    assign hit[p*PAT_PER_POD +: PAT_PER_POD] = pif.pat_hit;
    assign rng_hit[p] = pif.in_range;
  end
  // Align sample data and flag with the registered compare results
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      data_d1 <= '0;
      flag_d1 <= 1'b0;
    end else begin
      data_d1 <= probe_q;
      flag_d1 <= flag_q;
    end
  end

  // ------------------------------------------------------------
  // Level combiner and resource budget
  // ------------------------------------------------------------
  // Fixed grouping: (AND terms and ranges and flag) and (OR of OR terms)
  function automatic logic level_match(input logic [NP-1:0] h,
      input logic [NPODS-1:0] r, input logic f, input logic [NP-1:0] au,
      input logic [NP-1:0] ou, input logic [NPODS-1:0] ru, input logic fu);
    logic a;
    logic o;
    a = &(h | ~au) & &(r | ~ru) & (f | ~fu);
    o = (ou == '0) ? 1'b1 : |(h & ou);
    level_match = a & o;
  endfunction : level_match
  logic [MAX_LEVELS-1:0] lvl_hit;
  always_comb begin
    for (int l = 0; l < MAX_LEVELS; l++) begin
      lvl_hit[l] = level_match(hit, rng_hit, flag_d1,
        level_and_use[l*NP +: NP], level_or_use[l*NP +: NP],
        level_range_use[l*NPODS +: NPODS], level_flag_use[l]);
    end
  end
  function automatic int popc(input logic [NP-1:0] v);
    popc = 0;
    for (int i = 0; i < NP; i++) begin
      popc += int'(v[i]);
    end
  endfunction : popc
  // Comparator, range and combiner budget check over all used levels
  logic over;
  always_comb begin
    logic [NP-1:0] used;
    logic [NPODS-1:0] rused;
    int comb;
    int lim;
    used = '0;
    rused = '0;
    comb = 0;
    over = 1'b0;
    lim = half ? HALF_CH_PATS : PAT_PER_POD;
    for (int l = 0; l < MAX_LEVELS; l++) begin
      if (l <= int'(last_level)) begin
        used |= level_and_use[l*NP +: NP] | level_or_use[l*NP +: NP];
        rused |= level_range_use[l*NPODS +: NPODS];
        // Mixing costs a combiner per term, not one per level
        if ((level_and_use[l*NP +: NP] != '0) &&
            (level_or_use[l*NP +: NP] != '0)) begin
          comb += popc(level_and_use[l*NP +: NP]) +
            popc(level_or_use[l*NP +: NP]);
        end else begin
          comb += 1;
        end
      end
    end
    if (store_qual_en) begin
      used |= store_use;
    end
    for (int p = 0; p < NPODS; p++) begin
      if (popc(NP'(used[p*PAT_PER_POD +: PAT_PER_POD])) +
          (half ? int'(rused[p]) : 0) > lim) begin
        over = 1'b1;
      end
    end
    if (comb > COMBINERS) begin
      over = 1'b1;
    end
    if (half && int'(last_level) >= HALF_CH_MAX_LEVELS) begin
      over = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  ats_state_t state;
  logic [AW:0] count;
  wire logic eventual = (mode == ATS_MODE_EVENTUAL) ||
    (mode == ATS_MODE_HALF_EVT);
  wire logic cur_hit = lvl_hit[level];
  wire logic final_hit = cur_hit && (level == last_level);
  wire logic keep = !store_qual_en || |(hit & store_use);
  wire logic writing = (state == ATS_ARMED || state == ATS_POST) && keep;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state <= ATS_IDLE;
    end else begin
      case (state)
        ATS_IDLE, ATS_DONE, ATS_REJECT: begin
          if (start) begin
            state <= over ? ATS_REJECT : ATS_ARMED;
          end
        end
        ATS_ARMED: begin
          if (final_hit) begin
            state <= ATS_POST;
          end
        end
        ATS_POST: begin
          if (writing && count == (AW+1)'(DEPTH - 1)) begin
            state <= ATS_DONE;
          end
        end
        default: begin
          state <= ATS_IDLE;
        end
      endcase
    end
  end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      level <= LEVEL_RESET;
    end else if (state != ATS_ARMED) begin
      level <= LEVEL_RESET;
    end else if (cur_hit && level != last_level) begin
      level <= level + 1'b1;
    end else if (!cur_hit && !eventual) begin
      level <= LEVEL_RESET;
    end
    // Eventual mode holds the level on a miss
  end
  // Trace memory fill count; pre-trigger wraps, post-trigger fills up
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      count <= '0;
    end else if (state == ATS_IDLE || state == ATS_DONE ||
        state == ATS_REJECT) begin
      count <= '0;
    end else if (state == ATS_ARMED && final_hit) begin
      count <= '0;
    end else if (writing) begin
      count <= count + 1'b1;
    end
  end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      store_data <= '0;
      store_valid <= 1'b0;
    end else begin
      store_data <= data_d1;
      store_valid <= writing;
    end
  end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      triggered <= 1'b0;
      done <= 1'b0;
      running <= 1'b0;
      reject <= 1'b0;
    end else begin
      triggered <= (state == ATS_POST) || (state == ATS_DONE);
      done <= state == ATS_DONE;
      running <= (state == ATS_ARMED) || (state == ATS_POST);
      reject <= state == ATS_REJECT;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  eventual_hold_a: assert property (
    @(posedge clock) disable iff (!resetn)
    (state == ATS_ARMED && eventual && $past(state) == ATS_ARMED &&
     $past(state, 2) == ATS_ARMED && $past(level) != LEVEL_RESET)
    |-> level != LEVEL_RESET)
    else $error("eventual mode fell back to first level");
  immediate_reset_a: assert property (
    @(posedge clock) disable iff (!resetn)
    (state == ATS_ARMED && !eventual && !cur_hit)
    |=> level == LEVEL_RESET)
    else $error("immediate mode did not restart on a miss");
  reject_start_a: assert property (
    @(posedge clock) disable iff (!resetn)
    (state == ATS_IDLE && start && over) |=> state == ATS_REJECT
    ##1 reject)
    else $error("over-budget setup was not rejected");
  trigger_post_a: assert property (
    @(posedge clock) disable iff (!resetn)
    (state == ATS_ARMED && final_hit) |=> state == ATS_POST ##1 triggered)
    else $error("final level match did not trigger");
  store_qual_a: assert property (
    @(posedge clock) disable iff (!resetn)
    (store_qual_en && running && !(|(hit & store_use))) |=> !store_valid)
    else $error("unqualified sample was stored");
  flag_gate_a: assert property (
    @(posedge clock) disable iff (!resetn)
    (state == ATS_ARMED && level_flag_use[level] && !flag_d1 &&
     level != last_level) |=> level != $past(level) + 2'h1)
    else $error("level advanced without its flag");
endmodule : ats_sequencer
`default_nettype wire

// ==== ats_target.sv ====
// Model of the probed target and of the module that drives the flag
`timescale 1ns/1ps
`default_nettype none
module ats_target #(
  parameter int NPODS = 2
) (
  input wire logic clock,
  output logic [NPODS*ats_pkg::POD_BITS-1:0] probe,
  output logic flag_in
);
  import ats_pkg::*;
  initial begin
    probe = '0;
    flag_in = 1'b0;
  end
  // Pins change just after an edge; the probe never floats, so no
  // released level is modelled here
  task automatic put(input logic [POD_BITS-1:0] p0,
      input logic [POD_BITS-1:0] p1, input logic f);
    @(posedge clock);
    probe <= {p1, p0};
    flag_in <= f;
  endtask : put
endmodule : ats_target
`default_nettype wire

// ==== tb_analyzer_trigger_sequencer.sv ====
// Self-checking bench of the trigger sequencer against a target model
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
      n_errors++; \
      $display("wrong value %s expected %h seen %h", nm, exp, got); \
    end \
  end
`define WAITC(c, n) \
  for (wi = 0; wi < (n) && !(c); wi++) @(negedge clock); \
  if (!(c)) begin \
    n_errors++; \
    end_of_test(); \
  end
module tb_analyzer_trigger_sequencer;
  import ats_pkg::*;
  localparam int NPODS = 2;
  localparam int DEPTH = 16;
  localparam int NP = NPODS*PAT_PER_POD;
  localparam int W = POD_BITS;
  logic clock;
  logic resetn;
  logic [NPODS*W-1:0] probe;
  logic flag_in;
  logic start;
  ats_mode_t mode;
  logic [LEVEL_W-1:0] last_level;
  logic [NP*W-1:0] pat_value;
  logic [NP*W-1:0] pat_mask;
  logic [NPODS*W-1:0] range_lo;
  logic [NPODS*W-1:0] range_hi;
  logic [MAX_LEVELS*NP-1:0] level_and_use;
  logic [MAX_LEVELS*NP-1:0] level_or_use;
  logic [MAX_LEVELS*NPODS-1:0] level_range_use;
  logic [MAX_LEVELS-1:0] level_flag_use;
  logic store_qual_en;
  logic [NP-1:0] store_use;
  logic [NPODS*W-1:0] store_data;
  logic store_valid, triggered, done, running, reject;
  logic [LEVEL_W-1:0] level;
  int n_errors = 0;
  int total_checks = 0;
  int wi;
  int n_stored = 0;
  bit sq_on = 0;

  // ----------------------------------------
  // Clock, target model and design
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  ats_target #(.NPODS(NPODS)) i_ats_target (
    .clock(clock),
    .probe(probe),
    .flag_in(flag_in)
  );
  ats_sequencer #(.NPODS(NPODS), .DEPTH(DEPTH)) i_ats_sequencer (
    .clock(clock),
    .resetn(resetn),
    .probe(probe),
    .flag_in(flag_in),
    .start(start),
    .mode(mode),
    .last_level(last_level),
    .pat_value(pat_value),
    .pat_mask(pat_mask),
    .range_lo(range_lo),
    .range_hi(range_hi),
    .level_and_use(level_and_use),
    .level_or_use(level_or_use),
    .level_range_use(level_range_use),
    .level_flag_use(level_flag_use),
    .store_qual_en(store_qual_en),
    .store_use(store_use),
    .store_data(store_data),
    .store_valid(store_valid),
    .triggered(triggered),
    .done(done),
    .running(running),
    .reject(reject),
    .level(level)
  );

  // Every sample kept while sq_on is set must carry 4 or 8 in the top digit of pod 1
  always @(negedge clock) begin
    if (sq_on && store_valid === 1'b1) begin
      n_stored++;
      `CHK("kept_digit", 1'b1, store_data[W+15 -: 4] inside {4'h4, 4'h8})
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test

  task automatic clear_setup();
    pat_value <= '0;
    pat_mask <= '0;
    range_lo <= '0;
    range_hi <= '0;
    level_and_use <= '0;
    level_or_use <= '0;
    level_range_use <= '0;
    level_flag_use <= '0;
    store_qual_en <= 1'b0;
    store_use <= '0;
  endtask : clear_setup

  task automatic set_cmp(input int p, input int k,
      input logic [W-1:0] v, input logic [W-1:0] m);
    pat_value[(p*4+k)*W +: W] <= v;
    pat_mask[(p*4+k)*W +: W] <= m;
  endtask : set_cmp

  task automatic put(input logic [W-1:0] a, input logic [W-1:0] b,
      input logic f);
    i_ats_target.put(a, b, f);
  endtask : put

  task automatic idle(input int n);
    repeat (n) put(17'h0, 17'h0, 1'b0);
    @(negedge clock);
  endtask : idle

  // Setup is held stable from the start edge on
  task automatic go(input ats_mode_t m, input logic [LEVEL_W-1:0] last);
    @(posedge clock);
    mode <= m;
    last_level <= last;
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
    `WAITC(running === 1'b1 || reject === 1'b1, 8)
  endtask : go

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_immediate();
    clear_setup();
    set_cmp(0, 0, 17'h01111, 17'h0ffff);
    set_cmp(0, 1, 17'h02222, 17'h0ffff);
    set_cmp(0, 2, 17'h03333, 17'h0ffff);
    set_cmp(0, 3, 17'h04444, 17'h0ffff);
    level_and_use[0] <= 1'b1;
    level_flag_use[0] <= 1'b1;
    level_and_use[NP+1] <= 1'b1;
    level_or_use[2*NP+2] <= 1'b1;
    level_or_use[2*NP+3] <= 1'b1;
    go(ATS_MODE_IMMEDIATE, 2'h2);
    put(17'h01111, 17'h0, 1'b1);
    put(17'h02222, 17'h0, 1'b1);
    put(17'h00007, 17'h0, 1'b1);
    put(17'h03333, 17'h0, 1'b1);
    idle(10);
    `CHK("trig_after_gap", 1'b0, triggered)
    `CHK("level_after_gap", 2'h0, level)
    put(17'h01111, 17'h0, 1'b0);
    put(17'h02222, 17'h0, 1'b0);
    put(17'h03333, 17'h0, 1'b0);
    idle(10);
    `CHK("trig_flag_low", 1'b0, triggered)
    put(17'h01111, 17'h0, 1'b1);
    put(17'h02222, 17'h0, 1'b1);
    put(17'h04444, 17'h0, 1'b1);
    idle(1);
    `WAITC(triggered === 1'b1, 20)
    `CHK("trig_or_level", 1'b1, triggered)
    `WAITC(done === 1'b1, 4*DEPTH)
    `CHK("fill_len", 1'b1, wi == DEPTH)
    `CHK("run_after_full", 1'b0, running)
  endtask : t_immediate

  task automatic t_eventual();
    clear_setup();
    set_cmp(0, 0, 17'h00000, 17'h0ffff);
    set_cmp(0, 1, 17'h05555, 17'h0ffff);
    set_cmp(0, 2, 17'h0aaaa, 17'h0ffff);
    set_cmp(1, 0, 17'h04000, 17'h0f000);
    set_cmp(1, 1, 17'h08000, 17'h0f000);
    level_and_use[0] <= 1'b1;
    level_and_use[NP+1] <= 1'b1;
    level_and_use[2*NP+2] <= 1'b1;
    store_qual_en <= 1'b1;
    store_use[4] <= 1'b1;
    store_use[5] <= 1'b1;
    go(ATS_MODE_EVENTUAL, 2'h2);
    sq_on = 1'b1;
    put(17'h01234, 17'h04abc, 1'b0);
    put(17'h05555, 17'h01234, 1'b0);
    put(17'h00000, 17'h08001, 1'b0);
    idle(10);
    `CHK("level_kept", 2'h2, level)
    `CHK("no_early_trig", 1'b0, triggered)
    put(17'h0aaaa, 17'h02222, 1'b0);
    for (int i = 0; i < 2*DEPTH; i++) begin
      put(17'h0, (i % 2) ? 17'h08000 + i : 17'h04000 + i, 1'b0);
    end
    @(negedge clock);
    `CHK("eventual_trig", 1'b1, triggered)
    `WAITC(done === 1'b1, 16)
    `CHK("kept_count", 1'b1, n_stored >= DEPTH)
    sq_on = 1'b0;
  endtask : t_eventual

  task automatic t_range();
    clear_setup();
    range_lo <= {17'h00300, 17'h00100};
    range_hi <= {17'h00400, 17'h00200};
    level_range_use[1:0] <= 2'h3;
    go(ATS_MODE_IMMEDIATE, 2'h0);
    put(17'h00200, 17'h00401, 1'b0);
    idle(8);
    `CHK("one_range_out", 1'b0, triggered)
    put(17'h00200, 17'h00300, 1'b0);
    idle(1);
    `WAITC(triggered === 1'b1, 16)
    `CHK("both_in_range", 1'b1, triggered)
    `WAITC(done === 1'b1, 4*DEPTH)
  endtask : t_range

  // Reset after a rejected start, so that a later reject cannot be a stale one
  task automatic pulse_reset();
    @(posedge clock);
    resetn <= 1'b0;
    @(negedge clock);
    `CHK("reject_in_reset", 1'b0, reject)
    `CHK("running_in_reset", 1'b0, running)
    @(posedge clock);
    resetn <= 1'b1;
    @(negedge clock);
  endtask : pulse_reset

  task automatic t_reject();
    clear_setup();
    level_and_use[2:0] <= 3'h7;
    store_qual_en <= 1'b1;
    store_use[3] <= 1'b1;
    go(ATS_MODE_HALF_IMM, 2'h0);
    idle(8);
    `CHK("over_budget", 1'b1, reject)
    `CHK("no_acquire", 1'b0, running)
    pulse_reset();
    clear_setup();
    level_and_use[NP-1:0] <= 8'h0f;
    level_or_use[NP-1:0] <= 8'hf0;
    level_and_use[NP] <= 1'b1;
    level_or_use[NP+4] <= 1'b1;
    go(ATS_MODE_IMMEDIATE, 2'h1);
    `CHK("combiner_over", 1'b1, reject)
    pulse_reset();
    clear_setup();
    level_and_use[0] <= 1'b1;
    go(ATS_MODE_HALF_IMM, 2'h2);
    @(negedge clock);
    `CHK("half_levels", 1'b1, reject)
    clear_setup();
    go(ATS_MODE_HALF_EVT, 2'h0);
    `WAITC(running === 1'b1, 8)
    `CHK("start_after_reject", 1'b1, running)
    `CHK("reject_cleared", 1'b0, reject)
    `WAITC(done === 1'b1, 4*DEPTH)
    `CHK("half_evt_trig", 1'b1, triggered)
  endtask : t_reject

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    resetn = 1'b0;
    start = 1'b0;
    mode = ATS_MODE_IMMEDIATE;
    last_level = 2'h0;
    clear_setup();
    repeat (5) @(posedge clock);
    resetn <= 1'b1;
    t_immediate();
    t_eventual();
    t_range();
    t_reject();
    end_of_test();
  end
endmodule : tb_analyzer_trigger_sequencer
`default_nettype wire
